/* File: design/timer_ctl_irq.sv */
// Control, arming and interrupt logic of the dual timer with AXI4-Lite
`include "timer_ctl_defines.svh"

module timer_ctl_irq
    import timer_ctl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output      ctl_s        ctl,
    output      logic [1:0]  half_run,
    output      logic [1:0]  half_restart,
    input  wire logic [1:0]  timeout_evt,
    input  wire logic [1:0]  match_evt,
    input  wire logic [1:0]  capture_in,
    output      logic [1:0]  capture_evt,
    input  wire logic [1:0]  adc_trig_in,
    output      logic [1:0]  adc_trig_out,
    input  wire logic [1:0]  pwm_in,
    output      logic [1:0]  pwm_out,
    output      logic        irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction

    function automatic logic [31:0] lanes(input logic [3:0] s);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{s[i]}};
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic        aw_held_r;
    logic [11:0] aw_addr_r;
    logic        w_held_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;

    // Address and data are parked independently; the write lands once
    // both are in, so either order from the master is fine.
    wire wr_go = aw_held_r & w_held_r;
    wire [31:0] wbits = w_data_r & lanes(w_strb_r);
    wire wr_ctl = wr_go & hit(aw_addr_r, `CTL_OFFSET);
    wire wr_arm = wr_go & hit(aw_addr_r, `IEN_OFFSET);
    wire wr_dis = wr_go & hit(aw_addr_r, `DIS_OFFSET);
    wire wr_msk = wr_go & hit(aw_addr_r, `MSK_OFFSET);
    wire wr_sts = wr_go & hit(aw_addr_r, `STS_OFFSET);
    wire wr_ok  = wr_ctl | wr_arm | wr_dis | wr_msk | wr_sts;

    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready  = ~w_held_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (s_axi_awvalid & s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid & s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [15:0] ctl_r;
    wire  [15:0] ctl_nxt = wr_ctl ? (wbits[15:0] & `CTL_WMASK) : ctl_r;

    // Written at any time; keeping it stable while running is up to software
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_r <= `CTL_RESET;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    assign ctl = ctl_s'(ctl_r);

    // ------------------------------------------------------------------
    // Counter steering and capture edges
    // ------------------------------------------------------------------
    logic [1:0] run_r;
    logic [1:0] restart_r;
    logic [1:0] en_prev_r;
    logic [1:0] cap_prev_r;
    logic [1:0] cap_evt_r;

    wire [1:0] en_w  = {ctl.b.enable, ctl.a.enable};
    wire [1:0] frz_w = {ctl.b.freeze, ctl.a.freeze};
    wire [1:0] run_w = en_w & ~frz_w;
    wire [1:0] rise_w = capture_in & ~cap_prev_r;
    wire [1:0] fall_w = ~capture_in & cap_prev_r;

    function automatic logic edge_hit(input edge_sel_e sel,
                                      input logic r,
                                      input logic f);
        case (sel)
            EDGE_RISE: return r;
            EDGE_FALL: return f;
            EDGE_BOTH: return r | f;
            default:   return 1'b0;
        endcase
    endfunction

    wire [1:0] cap_hit = run_w & {
        edge_hit(ctl.b.edge_sel, rise_w[1], fall_w[1]),
        edge_hit(ctl.a.edge_sel, rise_w[0], fall_w[0])};

    // Restart pulses on the enable rising; a freeze release gives none,
    // so the datapath keeps the held count.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            run_r      <= 2'h0;
            restart_r  <= 2'h0;
            en_prev_r  <= 2'h0;
            cap_prev_r <= 2'h0;
            cap_evt_r  <= 2'h0;
        end else begin
            run_r      <= run_w;
            restart_r  <= en_w & ~en_prev_r;
            en_prev_r  <= en_w;
            cap_prev_r <= capture_in;
            cap_evt_r  <= cap_hit;
        end
    end

    assign half_run     = run_r;
    assign half_restart = restart_r;
    assign capture_evt  = cap_evt_r;

    // ------------------------------------------------------------------
    // Trigger and PWM outputs
    // ------------------------------------------------------------------
    logic [1:0] trig_r;
    logic [1:0] pwm_r;

    // In complementary mode half B follows A inverted, then each half
    // applies its own polarity bit.
    wire pwm_b_raw = ctl.a.top ? ~pwm_in[0] : pwm_in[1];
    wire [1:0] pwm_nxt = {pwm_b_raw ^ ctl.b.invert,
                          pwm_in[0] ^ ctl.a.invert};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trig_r <= 2'h0;
            pwm_r  <= 2'h0;
        end else begin
            trig_r <= adc_trig_in & {ctl.b.trig_en, ctl.a.trig_en};
            pwm_r  <= pwm_nxt;
        end
    end

    assign adc_trig_out = trig_r;
    assign pwm_out      = pwm_r;

    // ------------------------------------------------------------------
    // Arming, status and interrupt
    // ------------------------------------------------------------------
    logic [10:0] armed_r;
    logic [10:0] sts_r;
    logic        irq_r;

    wire [10:0] arm_set = wr_arm ? wbits[10:0] & `IRQ_BITS : 11'h000;
    wire [10:0] arm_clr = wr_dis ? wbits[10:0] & `IRQ_BITS : 11'h000;
    wire [10:0] armed_nxt = (armed_r | arm_set) & ~arm_clr;
    wire [10:0] sts_clr = wr_sts ? wbits[10:0] : 11'h000;
    wire [10:0] ev_w = {cap_hit[1], match_evt[1], timeout_evt[1], 5'h00,
                        cap_hit[0], match_evt[0], timeout_evt[0]};
    // Set wins over a clear landing in the same cycle
    wire [10:0] sts_nxt = (sts_r & ~sts_clr) | ev_w;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            armed_r <= 11'h000;
            sts_r   <= 11'h000;
            irq_r   <= 1'b0;
        end else begin
            armed_r <= armed_nxt;
            sts_r   <= sts_nxt;
            irq_r   <= |(sts_nxt & armed_nxt);
        end
    end

    assign irq = irq_r;

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    wire rd_go  = s_axi_arvalid & s_axi_arready;
    wire rd_ctl = hit(s_axi_araddr, `CTL_OFFSET);
    wire rd_wo  = hit(s_axi_araddr, `IEN_OFFSET) |
                  hit(s_axi_araddr, `DIS_OFFSET);
    wire rd_msk = hit(s_axi_araddr, `MSK_OFFSET);
    wire rd_sts = hit(s_axi_araddr, `STS_OFFSET);
    wire [31:0] rd_mux = rd_ctl ? {16'h0000, ctl_r} :
                         rd_msk ? {21'h000000, armed_r} :
                         rd_sts ? {21'h000000, sts_r} :
                         32'h0000_0000;
    wire rd_ok = rd_ctl | rd_wo | rd_msk | rd_sts;

    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    half_stop_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ctl_r[8] |=> !half_run[1])
        else $error("half B runs while disabled");
    freeze_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ctl_r[1] |=> !half_run[0])
        else $error("half A runs while frozen");
    edge_rsvd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ctl_r[3:2] == 2'b10 |=> !capture_evt[0])
        else $error("reserved edge select gave an event");
    edge_fall_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        run_w[1] && ctl_r[11:10] == 2'b01 && fall_w[1]
        |=> capture_evt[1])
        else $error("falling edge missed on half B");
    trig_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !ctl_r[5] |=> !adc_trig_out[0])
        else $error("trigger passed while gated");
    pwm_invert_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> pwm_out[0] == ($past(pwm_in[0]) ^ $past(ctl_r[6])))
        else $error("half A polarity wrong");
    pwm_compl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !sys_rst && ctl_r[7] && ctl_r[6] == ctl_r[14]
        |=> pwm_out[1] != pwm_out[0])
        else $error("outputs not complementary");
    arm_a_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_arm && wbits[2] |=> armed_r[2])
        else $error("half A event source not armed");
    arm_b_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_arm && wbits[8] |=> armed_r[8])
        else $error("half B timeout source not armed");
    restart_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(ctl_r[0]) |=> half_restart[0] ##1 !half_restart[0])
        else $error("no single restart pulse");
    resume_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(ctl_r[1]) && ctl_r[0] && $past(ctl_r[0])
        |=> half_run[0] && !half_restart[0])
        else $error("freeze release restarted counter");
    disarm_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_dis && wbits[10] |=> !armed_r[10])
        else $error("disarm did not clear");
    mask_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rd_go && rd_msk |=> s_axi_rdata[10:0] == $past(armed_r))
        else $error("armed state read wrong");
    arm_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wr_arm && !wbits[1] |=> armed_r[1] == $past(armed_r[1]))
        else $error("zero write changed armed state");
    arm_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        rd_go && hit(s_axi_araddr, `IEN_OFFSET)
        |=> s_axi_rdata == 32'h0000_0000)
        else $error("arm register read not zero");

endmodule

/* File: design/timer_ctl_defines.svh */
// Register map, field positions and reset values of the timer control block
// Functional notes
// - Bit 0 enables half A, bit 8 enables half B; set means counting
// - Bit 1 (A) and bit 9 (B) freeze the counter at its value
// - Bits 3:2 and 11:10 pick capture edge: rise, fall, both; 2 reserved
// - Bit 5 (A) and bit 13 (B) pass the converter trigger when set
// - Bit 6 (A) and bit 14 (B) invert the PWM output when set
// - Bit 7 makes B the complement of A before the polarity bits apply; it is set after reset
// - Arm register bits 0, 1, 2 arm A timeout, match, event interrupts
// - Arm register bits 8, 9, 10 arm B timeout, match, event interrupts
// - Re-enabling a half restarts its counter from the reset value
// - Clearing the freeze bit resumes counting from the held value
// - Disarm register, same layout; writing one disarms that source
// - Armed-state register reads one for each source that is not masked
`ifndef TIMER_CTL_DEFINES_SVH
`define TIMER_CTL_DEFINES_SVH

// ----------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------
`define CTL_OFFSET  12'h00C
`define IEN_OFFSET  12'h010
`define DIS_OFFSET  12'h014
`define MSK_OFFSET  12'h018
`define STS_OFFSET  12'h01C

// ----------------------------------------------------------------------
// Values and fields
// ----------------------------------------------------------------------
`define CTL_RESET   16'h0080
`define CTL_WMASK   16'h6FEF
`define IRQ_BITS    11'h707
`define B_SHIFT     8
`define SRC_TOUT    0
`define SRC_MATCH   1
`define SRC_EVT     2
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: design/timer_ctl_pkg.sv */
// Types shared by the timer control block
package timer_ctl_pkg;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_RSVD = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_sel_e;

    // One byte of the control register; top is the complement bit in A
    typedef struct packed {
        logic      top;
        logic      invert;
        logic      trig_en;
        logic      rsvd;
        edge_sel_e edge_sel;
        logic      freeze;
        logic      enable;
    } half_ctl_s;

    typedef struct packed {
        half_ctl_s b;
        half_ctl_s a;
    } ctl_s;

endpackage

/* File: tb/dual_timer_control_irq_enable_tb.sv */
// Self-checking bench of the timer control and interrupt arming block
`include "timer_ctl_defines.svh"

module dual_timer_control_irq_enable_tb
    import timer_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        sys_clk, sys_rst, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, m;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    ctl_s        ctl;
    logic [1:0]  half_run, half_restart, timeout_evt, match_evt, capture_in;
    logic [1:0]  capture_evt, adc_trig_in, adc_trig_out, pwm_in, pwm_out;
    logic [15:0] c;
    int          error_cnt, n_checks, cycles, r0, r1;
    int          rs_cnt [2];
    int          cap_cnt [2];
    localparam logic [15:0] run_ctl [7] = '{16'h0000, 16'h0101, 16'h0103,
        16'h0101, 16'h0301, 16'h0000, 16'h0101};
    localparam int run_exp [7] = '{0, 3, 2, 3, 1, 0, 3};
    localparam int rs_exp [7] = '{0, 3, 0, 0, 0, 0, 3};
    localparam logic [15:0] out_ctl [5] = '{16'h0000, 16'h0060, 16'h2080,
        16'h60A0, 16'h40C0};
    localparam int cap_exp [4] = '{1, 1, 0, 2};
    localparam int src_bit [6] = '{0, 1, 2, 8, 9, 10};

    // ----------------------------------------
    // Design
    // ----------------------------------------
    timer_ctl_irq dut (
        .sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ctl, .half_run, .half_restart,
        .timeout_evt, .match_evt, .capture_in, .capture_evt, .adc_trig_in,
        .adc_trig_out, .pwm_in, .pwm_out, .irq
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Pulse counters and hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        for (int i = 0; i < 2; i++) begin
            if (half_restart[i] === 1'b1) rs_cnt[i] <= rs_cnt[i] + 1;
            if (capture_evt[i] === 1'b1) cap_cnt[i] <= cap_cnt[i] + 1;
        end
        if (cycles == 4000) begin
            error_cnt++;
            $display("BAD t=%0t timeout", $time);
            summarize();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Bready and rready stay high: the bench never stalls an answer
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er = `RESP_OKAY);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!aw || !w) begin
            @(posedge sys_clk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er = `RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // One source event on the half that bit b belongs to
    task automatic fire(input int b);
        logic [1:0] h;
        h = (b >= 8) ? 2'b10 : 2'b01;
        case (b % 8)
            0: timeout_evt <= h;
            1: match_evt <= h;
            default: capture_in <= h;
        endcase
        @(posedge sys_clk);
        timeout_evt <= 2'b00;
        match_evt <= 2'b00;
        capture_in <= 2'b00;
        cyc(6);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        sys_rst <= 1'b1;
        s_axi_awaddr <= 12'h000;
        s_axi_araddr <= 12'h000;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_bready <= 1'b1;
        s_axi_rready <= 1'b1;
        timeout_evt <= 2'b00;
        match_evt <= 2'b00;
        capture_in <= 2'b00;
        adc_trig_in <= 2'b00;
        pwm_in <= 2'b00;
        cyc(20);
        sys_rst <= 1'b0;
        chk({16'h0000, ctl}, 32'h0000_0080);
        rd(`CTL_OFFSET, 32'h0000_0080);
        rd(`MSK_OFFSET, 32'h0);
        rd(12'h040, 32'h0, `RESP_SLVERR);
        wr(12'h040, 32'hFFFF_FFFF, `RESP_SLVERR);
        wr(`CTL_OFFSET, 32'hFFFF_FFFF);
        rd(`CTL_OFFSET, 32'h0000_6FEF);
        chk({16'h0000, ctl}, 32'h0000_6FEF);
        foreach (run_ctl[k]) begin
            r0 = rs_cnt[0];
            r1 = rs_cnt[1];
            wr(`CTL_OFFSET, {16'h0000, run_ctl[k]});
            cyc(3);
            chk({30'h0, half_run}, run_exp[k]);
            chk(rs_cnt[0] - r0 + 2 * (rs_cnt[1] - r1), rs_exp[k]);
        end
        foreach (out_ctl[k]) begin
            c = out_ctl[k];
            wr(`CTL_OFFSET, {16'h0000, c});
            for (int p = 0; p < 4; p++) begin
                pwm_in <= p[1:0];
                adc_trig_in <= p[1:0];
                cyc(3);
                chk({30'h0, adc_trig_out}, p[1:0] & {c[13], c[5]});
                chk({30'h0, pwm_out}, {(c[7] ? ~p[0] : p[1]) ^ c[14],
                    p[0] ^ c[6]});
            end
        end
        // Edge select is changed only with the half stopped
        for (int e = 0; e < 4; e++) begin
            c = {4'h0, e[1:0], 6'h00, e[1:0], 2'b00};
            wr(`CTL_OFFSET, {16'h0000, c});
            wr(`CTL_OFFSET, {16'h0000, c | 16'h0101});
            r0 = cap_cnt[0];
            r1 = cap_cnt[1];
            capture_in <= 2'b11;
            cyc(6);
            capture_in <= 2'b00;
            cyc(6);
            chk(cap_cnt[0] - r0, cap_exp[e]);
            chk(cap_cnt[1] - r1, cap_exp[e]);
            wr(`CTL_OFFSET, {16'h0000, c});
        end
        wr(`CTL_OFFSET, 32'h0000_0101);
        wr(`STS_OFFSET, 32'h0000_0707);
        rd(`STS_OFFSET, 32'h0);
        foreach (src_bit[k]) begin
            m = 32'h1 << src_bit[k];
            wr(`DIS_OFFSET, 32'h0000_0707);
            wr(`IEN_OFFSET, m);
            wr(`IEN_OFFSET, 32'h0);
            rd(`MSK_OFFSET, m);
            rd(`IEN_OFFSET, 32'h0);
            fire(src_bit[k]);
            chk({31'h0, irq}, 32'h1);
            rd(`STS_OFFSET, m);
            wr(`DIS_OFFSET, m);
            chk({31'h0, irq}, 32'h0);
            rd(`MSK_OFFSET, 32'h0);
            wr(`IEN_OFFSET, 32'h0000_0707);
            chk({31'h0, irq}, 32'h1);
            wr(`STS_OFFSET, m);
            chk({31'h0, irq}, 32'h0);
            rd(`STS_OFFSET, 32'h0);
        end
        summarize();
    end
endmodule
